// ==== src/gpio_port1_port2.sv ====
// Two small GPIO ports with an APB register slave.
// Assumes one clock pclk; pin inputs pass through a two-stage synchroniser.
`timescale 1ns/1ps
`include "gpio_defines.svh"
module gpio_port1_port2 (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] port_a_in,
	output gpio_pkg::pad_drive_t [1:0] port_a_pad,
	output logic [1:0] port_a_pullup,
	input wire logic [2:0] port_b_in,
	output gpio_pkg::pad_drive_t [2:0] port_b_pad,
	input wire logic serial_tx_data,
	input wire logic serial_rx_claim,
	input wire logic serial_clk_claim,
	input wire logic serial_clk_oe,
	input wire logic serial_clk_out,
	output logic ext_int_line_3,
	output logic ext_int_line_0,
	output logic timer_trigger_input
);
	import gpio_pkg::*;

	// Port A index 1 is pin a7, index 0 is pin a4
	func_sel_t sel_q, sel_d;
	logic [1:0] a_dir_q, a_dir_d;
	logic [1:0] a_dat_q, a_dat_d;
	logic [1:0] a_pu_q, a_pu_d;
	logic [2:0] b_dir_q, b_dir_d;
	logic [2:0] b_dat_q, b_dat_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] a_sync;
	logic [2:0] b_sync;
	logic [1:0] a_func;
	logic [1:0] a_dir_eff;
	logic [2:0] b_ovr_en;
	logic [2:0] b_ovr_oe;
	logic [2:0] b_ovr_o;
	logic wr_en;
	logic rd_en;
	logic hit;
	logic [7:0] rd_byte;
	logic [7:0] wb;

	// Zero wait state slave; unmapped addresses flag an error
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	assign wb = pwdata[7:0];

	// Address decode for the error response
	always_comb begin
		unique case (paddr)
			`OFS_PIN_FUNCTION_SELECT, `OFS_PORT_A_DIRECTION, `OFS_PORT_A_OUTPUT_DATA,
			`OFS_PORT_A_PULLUP_ENABLE, `OFS_PORT_B_DIRECTION,
			`OFS_PORT_B_OUTPUT_DATA: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end
	assign pslverr = psel & penable & ~hit;

	// Pin sampling before the read path and interrupt routing
	gpio_sync2 #(.W(2)) u_sync_a (
		.pclk(pclk),
		.presetn(presetn),
		.din(port_a_in),
		.dout(a_sync)
	);
	gpio_sync2 #(.W(3)) u_sync_b (
		.pclk(pclk),
		.presetn(presetn),
		.din(port_b_in),
		.dout(b_sync)
	);

	// Register writes; reserved and unused bits are simply not stored
	always_comb begin
		sel_d = sel_q;
		a_dir_d = a_dir_q;
		a_dat_d = a_dat_q;
		a_pu_d = a_pu_q;
		b_dir_d = b_dir_q;
		b_dat_d = b_dat_q;
		if (wr_en) begin
			unique case (paddr)
				`OFS_PIN_FUNCTION_SELECT: begin
					sel_d.a7_func = wb[`SEL_A7_BIT];
					sel_d.a4_func = wb[`SEL_A4_BIT];
					sel_d.b2_txd = wb[`SEL_TXD_BIT];
				end
				`OFS_PORT_A_DIRECTION: a_dir_d = {wb[`PA_HI_BIT], wb[`PA_LO_BIT]};
				`OFS_PORT_A_OUTPUT_DATA: a_dat_d = {wb[`PA_HI_BIT], wb[`PA_LO_BIT]};
				`OFS_PORT_A_PULLUP_ENABLE: a_pu_d = {wb[`PA_HI_BIT], wb[`PA_LO_BIT]};
				`OFS_PORT_B_DIRECTION: b_dir_d = wb[`PB_TOP_BIT:0];
				`OFS_PORT_B_OUTPUT_DATA: b_dat_d = wb[`PB_TOP_BIT:0];
				default: ;
			endcase
		end
	end

	// Register state; every stored bit resets to zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_q <= func_sel_t'(`SEL_RESET);
			a_dir_q <= `PA_RESET;
			a_dat_q <= `PA_RESET;
			a_pu_q <= `PA_RESET;
			b_dir_q <= `PB_RESET;
			b_dat_q <= `PB_RESET;
		end else begin
			sel_q <= sel_d;
			a_dir_q <= a_dir_d;
			a_dat_q <= a_dat_d;
			a_pu_q <= a_pu_d;
			b_dir_q <= b_dir_d;
			b_dat_q <= b_dat_d;
		end
	end

	// Read mux: latch for outputs, synchronised pin for inputs
	always_comb begin
		rd_byte = 8'h00;
		unique case (paddr)
			`OFS_PIN_FUNCTION_SELECT: begin
				rd_byte[`SEL_A7_BIT] = sel_q.a7_func;
				rd_byte[`SEL_A4_BIT] = sel_q.a4_func;
				rd_byte[`SEL_TXD_BIT] = sel_q.b2_txd;
			end
			`OFS_PORT_A_DIRECTION, `OFS_PORT_B_DIRECTION: rd_byte = `WO_READ_VALUE;
			`OFS_PORT_A_OUTPUT_DATA: begin
				rd_byte = `PA_RESERVED_ONES;
				rd_byte[`PA_HI_BIT] = a_dir_q[1] ? a_dat_q[1] : a_sync[1];
				rd_byte[`PA_LO_BIT] = a_dir_q[0] ? a_dat_q[0] : a_sync[0];
			end
			`OFS_PORT_A_PULLUP_ENABLE: begin
				rd_byte = `PA_RESERVED_ONES;
				rd_byte[`PA_HI_BIT] = a_pu_q[1];
				rd_byte[`PA_LO_BIT] = a_pu_q[0];
			end
			`OFS_PORT_B_OUTPUT_DATA: begin
				rd_byte = `PB_RESERVED_ONES;
				rd_byte[`PB_TOP_BIT:0] = (b_dir_q & b_dat_q) | (~b_dir_q & b_sync);
			end
			default: rd_byte = 8'h00;
		endcase
		rdata_d = rdata_q;
		if (rd_en) begin
			rdata_d = {24'h000000, rd_byte};
		end
	end

	// Read data captured in setup so it stands from a flop in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= 32'h00000000;
		end else begin
			rdata_q <= rdata_d;
		end
	end
	assign prdata = rdata_q;

	// Port A function select overrides direction; function pins are inputs
	assign a_func = {sel_q.a7_func, sel_q.a4_func};
	assign a_dir_eff = a_dir_q & ~a_func;
	assign port_a_pullup = a_pu_q & ~a_dir_eff;

	generate
		for (genvar i = 0; i < 2; i++) begin : g_pa
			gpio_pin u_pin (
				.dir(a_dir_q[i]),
				.dat(a_dat_q[i]),
				.ovr_en(a_func[i]),
				.ovr_oe(1'b0),
				.ovr_o(1'b0),
				.pad(port_a_pad[i])
			);
		end
	endgenerate

	// Interrupt and trigger lines see the pin only when selected
	assign ext_int_line_3 = sel_q.a7_func & a_sync[1];
	assign timer_trigger_input = sel_q.a7_func & a_sync[1];
	assign ext_int_line_0 = sel_q.a4_func & a_sync[0];

	// Port B claims: b2 transmit, b1 receive input, b0 serial clock
	always_comb begin
		b_ovr_en = {sel_q.b2_txd, serial_rx_claim, serial_clk_claim};
		b_ovr_oe = {1'b1, 1'b0, serial_clk_oe};
		b_ovr_o = {serial_tx_data, 1'b0, serial_clk_out};
	end

	generate
		for (genvar j = 0; j < 3; j++) begin : g_pb
			gpio_pin u_pin (
				.dir(b_dir_q[j]),
				.dat(b_dat_q[j]),
				.ovr_en(b_ovr_en[j]),
				.ovr_oe(b_ovr_oe[j]),
				.ovr_o(b_ovr_o[j]),
				.pad(port_b_pad[j])
			);
		end
	endgenerate

	// Port A pads: general I/O follows direction, function pins never drive
	a_a7_gpio_out: assert property (@(posedge pclk) disable iff (!presetn)
		(!sel_q.a7_func && a_dir_q[1]) |-> (port_a_pad[1].oe && port_a_pad[1].o == a_dat_q[1]))
		else $error("a7 not driven as output");
	a_a4_gpio_out: assert property (@(posedge pclk) disable iff (!presetn)
		(!sel_q.a4_func && a_dir_q[0]) |-> (port_a_pad[0].oe && port_a_pad[0].o == a_dat_q[0]))
		else $error("a4 not driven as output");
	a_a7_gpio_in: assert property (@(posedge pclk) disable iff (!presetn)
		(!sel_q.a7_func && !a_dir_q[1]) |-> !port_a_pad[1].oe)
		else $error("a7 driven while input");
	a_func_input: assert property (@(posedge pclk) disable iff (!presetn)
		sel_q.a4_func |-> !port_a_pad[0].oe)
		else $error("a4 driven while selected");
	a_a7_func_in: assert property (@(posedge pclk) disable iff (!presetn)
		sel_q.a7_func |-> !port_a_pad[1].oe)
		else $error("a7 driven while selected");

	// Pull-ups judged against the pads and the stored pull-up and direction bits, not against the gating expression
	a_pullup_gate: assert property (@(posedge pclk) disable iff (!presetn)
		port_a_pad[1].oe |-> !port_a_pullup[1])
		else $error("pull-up on output");
	a_pullup_a4_off: assert property (@(posedge pclk) disable iff (!presetn)
		port_a_pad[0].oe |-> !port_a_pullup[0])
		else $error("a4 pull-up on output");
	a_pullup_on: assert property (@(posedge pclk) disable iff (!presetn)
		(a_pu_q[0] && !a_dir_q[0]) |-> port_a_pullup[0])
		else $error("a4 pull-up missing");
	a_pullup_off: assert property (@(posedge pclk) disable iff (!presetn)
		!a_pu_q[1] |-> !port_a_pullup[1])
		else $error("a7 pull-up without its bit");

	// Interrupt lines: silent unless selected, pin two edges late when selected
	a_int_follow: assert property (@(posedge pclk) disable iff (!presetn)
		(sel_q.a7_func && port_a_in[1]) ##1 sel_q.a7_func [*2]
		|-> ext_int_line_3 == $past(port_a_in[1], 2))
		else $error("int line lag");
	a_int0_follow: assert property (@(posedge pclk) disable iff (!presetn)
		(sel_q.a4_func && port_a_in[0]) ##1 sel_q.a4_func [*2]
		|-> ext_int_line_0 == $past(port_a_in[0], 2))
		else $error("int0 line lag");
	a_int_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!sel_q.a7_func |-> !(ext_int_line_3 || timer_trigger_input))
		else $error("a7 lines active while general I/O");
	a_int0_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!sel_q.a4_func |-> !ext_int_line_0)
		else $error("a4 line active while general I/O");

	// Port B: claims first, then direction and data
	a_b2_txd: assert property (@(posedge pclk) disable iff (!presetn)
		sel_q.b2_txd |-> (port_b_pad[2].oe && port_b_pad[2].o == serial_tx_data))
		else $error("b2 not transmit");
	a_b2_gpio: assert property (@(posedge pclk) disable iff (!presetn)
		!sel_q.b2_txd |-> (port_b_pad[2].oe == b_dir_q[2] && port_b_pad[2].o == b_dat_q[2]))
		else $error("b2 not general I/O");
	a_b_gpio_out: assert property (@(posedge pclk) disable iff (!presetn)
		(!serial_rx_claim && b_dir_q[1]) |-> port_b_pad[1].oe)
		else $error("b1 not out");
	a_b1_claim: assert property (@(posedge pclk) disable iff (!presetn)
		serial_rx_claim |-> !port_b_pad[1].oe)
		else $error("b1 driven while receiving");
	a_b0_claim: assert property (@(posedge pclk) disable iff (!presetn)
		serial_clk_claim |-> (port_b_pad[0].oe == serial_clk_oe && port_b_pad[0].o == serial_clk_out))
		else $error("b0 not serial clock");

	// Read path, one edge after the setup cycle that captures it
	a_wo_read: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_en && (paddr == `OFS_PORT_A_DIRECTION || paddr == `OFS_PORT_B_DIRECTION))
		|=> prdata == {24'h000000, `WO_READ_VALUE})
		else $error("direction read not ones");
	a_pa_reserved: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_en && paddr == `OFS_PORT_A_OUTPUT_DATA)
		|=> (prdata[7:0] & `PA_RESERVED_ONES) == `PA_RESERVED_ONES)
		else $error("reserved bits not one");
	a_pa_read_pin: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_en && paddr == `OFS_PORT_A_OUTPUT_DATA && !a_dir_q[0])
		|=> prdata[`PA_LO_BIT] == $past(port_a_in[0], 3))
		else $error("a4 pin not read");
	a_pb_read: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_en && paddr == `OFS_PORT_B_OUTPUT_DATA && b_dir_q[0]) |=> prdata[0] == $past(b_dat_q[0]))
		else $error("b0 latch not read");
endmodule : gpio_port1_port2

// ==== src/gpio_defines.svh ====
// Register offsets, field positions and reset values for the two-port GPIO block.
// Included by the top module and the synchroniser; definitions only.
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH

`define OFS_PIN_FUNCTION_SELECT 12'h000
`define OFS_PORT_A_DIRECTION 12'h004
`define OFS_PORT_A_OUTPUT_DATA 12'h008
`define OFS_PORT_A_PULLUP_ENABLE 12'h00c
`define OFS_PORT_B_DIRECTION 12'h010
`define OFS_PORT_B_OUTPUT_DATA 12'h014

`define SEL_A7_BIT 7
`define SEL_A4_BIT 4
`define SEL_TXD_BIT 1
`define PA_HI_BIT 7
`define PA_LO_BIT 4
`define PB_TX_PIN 2
`define PB_TOP_BIT 2

`define PA_RESERVED_ONES 8'h6f
`define PB_RESERVED_ONES 8'hf8
`define SEL_RESERVED_MASK 8'h92
`define WO_READ_VALUE 8'hff
`define PA_RESET 2'h0
`define PB_RESET 3'h0
`define SEL_RESET 3'h0
`define SYNC_RESET 1'h0

`endif

// ==== src/gpio_pkg.sv ====
// Types shared by the GPIO port modules.
// Assumes the defines header is on the include path.
package gpio_pkg;

	// One general-purpose pin as seen at the pad
	typedef struct packed {
		logic o;
		logic oe;
	} pad_drive_t;

	// Mode bits: a7 special, a4 special, b2 transmit
	typedef struct packed {
		logic a7_func;
		logic a4_func;
		logic b2_txd;
	} func_sel_t;

endpackage : gpio_pkg

// ==== src/gpio_sync2.sv ====
// Two-flip-flop synchroniser for a bus of pin levels.
// Assumes pins are asynchronous to pclk.
`timescale 1ns/1ps
`include "gpio_defines.svh"
module gpio_sync2 #(
	parameter int W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	// First stage feeds only the second
	always_comb begin
		meta_d = din;
		sync_d = meta_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= {W{`SYNC_RESET}};
			sync_q <= {W{`SYNC_RESET}};
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign dout = sync_q;
endmodule : gpio_sync2

// ==== src/gpio_pin.sv ====
// One general I/O pin: direction/data mux with an override from a peripheral.
// Assumes override inputs come from the function select register, constants or the serial ports of the top module.
`timescale 1ns/1ps
module gpio_pin (
	input wire logic dir,
	input wire logic dat,
	input wire logic ovr_en,
	input wire logic ovr_oe,
	input wire logic ovr_o,
	output gpio_pkg::pad_drive_t pad
);
	import gpio_pkg::*;

	// Peripheral claim wins over direction and data
	always_comb begin
		if (ovr_en) begin
			pad.oe = ovr_oe;
			pad.o = ovr_o;
		end else begin
			pad.oe = dir;
			pad.o = dat;
		end
	end
endmodule : gpio_pin

// ==== tb/gpio_port1_port2_tb.sv ====
// Self-checking bench for the two-port GPIO block and its APB slave.
// Assumes pin inputs settle within three pclk edges of the synchroniser.
`timescale 1ns/1ps
module gpio_port1_port2_tb;
	import gpio_pkg::*;
	typedef struct packed {
		logic [11:0] a;
		logic [7:0] w;
		logic [7:0] e;
	} row_t;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [1:0] port_a_in = 2'h0;
	pad_drive_t [1:0] port_a_pad;
	logic [1:0] port_a_pullup;
	logic [2:0] port_b_in = 3'h0;
	pad_drive_t [2:0] port_b_pad;
	logic serial_tx_data = 1'b0;
	logic serial_rx_claim = 1'b0;
	logic serial_clk_claim = 1'b0;
	logic serial_clk_oe = 1'b0;
	logic serial_clk_out = 1'b0;
	logic ext_int_line_3;
	logic ext_int_line_0;
	logic timer_trigger_input;
	int n_mismatch = 0;
	int checked = 0;
	logic [31:0] rd;
	logic err;
	// Write then read back; the 008 row relies on the 004 row before it, and the 014 row on the 010 row
	row_t rows [8] = '{
		'{12'h004, 8'h92, 8'hff},
		'{12'h008, 8'h90, 8'hff},
		'{12'h00c, 8'h00, 8'h6f},
		'{12'h00c, 8'hff, 8'hff},
		'{12'h010, 8'h07, 8'hff},
		'{12'h014, 8'h05, 8'hfd},
		'{12'h000, 8'hff, 8'h92},
		'{12'h000, 8'h00, 8'h00}
	};
	logic [7:0] rst_val [6] = '{8'h00, 8'hff, 8'h6f, 8'h6f, 8'hff, 8'hf8};

	gpio_port1_port2 DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .port_a_in(port_a_in),
		.port_a_pad(port_a_pad), .port_a_pullup(port_a_pullup),
		.port_b_in(port_b_in), .port_b_pad(port_b_pad),
		.serial_tx_data(serial_tx_data), .serial_rx_claim(serial_rx_claim),
		.serial_clk_claim(serial_clk_claim), .serial_clk_oe(serial_clk_oe),
		.serial_clk_out(serial_clk_out), .ext_int_line_3(ext_int_line_3),
		.ext_int_line_0(ext_int_line_0), .timer_trigger_input(timer_trigger_input)
	);

	// 100 MHz
	always #5 pclk = ~pclk;

	task automatic report_and_stop;
		if (n_mismatch == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	// One transfer; idles a cycle after so strobes never toggle twice in a step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (pready !== 1'b1) begin
			n_mismatch++;
			report_and_stop();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask : apb

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		cmp(rd, exp);
	endtask : rdc

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, {24'h0, rows[i].w});
			rdc(rows[i].a, {24'h0, rows[i].e});
		end
		// Both A pins drive high, B drives 101, pull-ups held off on outputs
		cmp(32'(port_a_pad), 32'hf);
		cmp(32'(port_a_pullup), 32'h0);
		cmp(32'(port_b_pad), 32'h37);
		// Inputs read the pin, not the latch
		port_a_in <= 2'h1;
		port_b_in <= 3'h2;
		apb(1'b1, 12'h004, 32'h0);
		apb(1'b1, 12'h010, 32'h0);
		rdc(12'h008, 32'h7f);
		rdc(12'h014, 32'hfa);
		cmp(32'({port_a_pad[1].oe, port_a_pad[0].oe, port_a_pullup}), 32'h3);
		port_a_in <= 2'h3;
		repeat (3) @(posedge pclk);
		cmp(32'({ext_int_line_3, ext_int_line_0, timer_trigger_input}), 32'h0);
		// Function select wins over an output direction
		apb(1'b1, 12'h004, 32'h90);
		apb(1'b1, 12'h000, 32'h92);
		cmp(32'({ext_int_line_3, ext_int_line_0, timer_trigger_input}), 32'h7);
		cmp(32'({port_a_pad[1].oe, port_a_pad[0].oe, port_a_pullup}), 32'h3);
		// Transmit and serial claims beat B direction and data
		apb(1'b1, 12'h010, 32'h7);
		serial_rx_claim <= 1'b1;
		serial_clk_claim <= 1'b1;
		serial_clk_oe <= 1'b1;
		@(posedge pclk);
		cmp(32'({port_b_pad[2], port_b_pad[1].oe, port_b_pad[0]}), 32'h9);
		serial_tx_data <= 1'b1;
		serial_clk_out <= 1'b1;
		@(posedge pclk);
		cmp(32'(port_b_pad[2]), 32'h3);
		cmp(32'(port_b_pad[0]), 32'h3);
		// Unmapped address is refused both ways
		apb(1'b1, 12'h018, 32'hff);
		cmp({31'h0, err}, 32'h1);
		apb(1'b0, 12'h018, 32'h0);
		cmp({31'h0, err}, 32'h1);
		cmp(rd, 32'h0);
		// Second reset from a busy state
		port_a_in <= 2'h0;
		port_b_in <= 3'h0;
		serial_rx_claim <= 1'b0;
		serial_clk_claim <= 1'b0;
		serial_clk_oe <= 1'b0;
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		cmp(32'({port_a_pad, port_b_pad, port_a_pullup}), 32'h0);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 6; i++) begin
			rdc(12'(4 * i), {24'h0, rst_val[i]});
		end
		report_and_stop();
	end
endmodule : gpio_port1_port2_tb
